// >>> core/dfsc_front_ctl.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module dfsc_front_ctl
	import dfsc_pkg::*;
(
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	// fetch side
	input  wire dfsc_fetch_type        fetch_in,
	output var  logic                  fetch_go_q,
	output var  logic                  fetch_drop_q,
	// decode side
	input  wire dfsc_slot_type         slot_bottom,
	input  wire dfsc_slot_type         slot_upper,
	input  wire logic [3:0]            cmpl_free,
	input  wire logic                  cmpl_empty,
	input  wire logic                  brq_full,
	input  wire logic                  genq_full,
	input  wire logic                  flush_active,
	input  wire logic                  ib_flush,
	input  wire logic                  psync_done,
	input  wire logic                  ctr_exec,
	input  wire logic                  lr_exec,
	output var  logic                  dec_bottom_q,
	output var  logic                  dec_upper_q,
	// issue side
	input  wire dfsc_cand_type         genq_head0,
	input  wire dfsc_cand_type         genq_head1,
	input  wire logic                  brq_valid,
	input  wire logic [UNITS-1:0]      rs_busy,
	output var  logic                  issue_g0_q,
	output var  logic                  issue_g1_q,
	output var  logic                  issue_b_q,
	// single-cycle units
	input  wire dfsc_su_type           su_one,
	input  wire dfsc_su_type           su_two,
	output var  logic [1:0]            su_go_q
);

	logic [2:0]     ctrl_q;
	logic [15:0]    dcnt_q;
	dfsc_psync_type ps_q;
	logic           br_lock_q;
	logic           ctr_pend_q;
	logic           lr_pend_q;
	logic           miss_pend_q;
	logic           ok_b;
	logic           ok_u;
	logic           common_ok;
	logic           dec_b;
	logic           dec_u;
	logic           fetch_go;
	logic           g0;
	logic           g1;
	logic           gb;
	logic [1:0]     su_start;
	logic [1:0]     su_busy;
	logic           wr_en;
	logic [31:0]    rd_val;
	logic           rd_hit;

	// position-independent checks for both slots
	dfsc_slot_check u_chk_bottom (
		.slot       (slot_bottom),
		.ctr_pend   (ctr_pend_q),
		.lr_pend    (lr_pend_q),
		.cmpl_empty (cmpl_empty),
		.brq_full   (brq_full),
		.ok         (ok_b)
	);

	dfsc_slot_check u_chk_upper (
		.slot       (slot_upper),
		.ctr_pend   (ctr_pend_q),
		.lr_pend    (lr_pend_q),
		.cmpl_empty (cmpl_empty),
		.brq_full   (brq_full),
		.ok         (ok_u)
	);

	// start logic of the two single-cycle units
	dfsc_su_start u_su_one (
		.pclk    (pclk),
		.presetn (presetn),
		.su      (su_one),
		.start   (su_start[0]),
		.busy    (su_busy[0])
	);

	dfsc_su_start u_su_two (
		.pclk    (pclk),
		.presetn (presetn),
		.su      (su_two),
		.start   (su_start[1]),
		.busy    (su_busy[1])
	);

	// fetch start conditions
	always_comb begin
		fetch_go = ctrl_q[CTRL_FETCH_EN];
		if (fetch_in.prio_pending) begin
			fetch_go = 1'b0;
		end
		if (miss_pend_q || fetch_in.itlb_miss || fetch_in.icache_miss) begin
			fetch_go = 1'b0;
		end
		if (!fetch_in.instq_room || !fetch_in.fq_room) begin
			fetch_go = 1'b0;
		end
	end

	// miss flag, a new miss wins over a service in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miss_pend_q <= 1'b0;
		end else begin
			if (fetch_in.itlb_miss || fetch_in.icache_miss) begin
				miss_pend_q <= 1'b1;
			end else if (fetch_in.miss_done) begin
				miss_pend_q <= 1'b0;
			end
		end
	end

	// fetch outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_go_q   <= 1'b0;
			fetch_drop_q <= 1'b0;
		end else begin
			fetch_go_q   <= fetch_go;
			fetch_drop_q <= fetch_in.stage2_tgt_hit && fetch_in.stage1_valid;
		end
	end

	// conditions shared by both slots
	always_comb begin
		common_ok = ctrl_q[CTRL_DECODE_EN];
		if (ps_q != PS_IDLE) begin
			common_ok = 1'b0;
		end
		if (flush_active) begin
			common_ok = 1'b0;
		end
		if (cmpl_free < CMPL_FREE_NEED) begin
			common_ok = 1'b0;
		end
		if (br_lock_q) begin
			common_ok = 1'b0;
		end
		if (genq_full) begin
			common_ok = 1'b0;
		end
	end

	// empty queue leaves slot invalid and ok_b low
	assign dec_b = common_ok && ok_b;

	// upper slot decisions, only two slots exist
	always_comb begin
		// upper only with bottom, two slots at most
		dec_u = dec_b && ok_u;
		if (slot_upper.brk_before) begin
			dec_u = 1'b0;
		end
		if (slot_bottom.brk_after || slot_bottom.post_sync) begin
			dec_u = 1'b0;
		end
		if (slot_bottom.branch_class && slot_upper.branch_class) begin
			dec_u = 1'b0;
		end
		// stop right behind a missed branch
		if (slot_bottom.uncond_tgt_miss) begin
			dec_u = 1'b0;
		end
		// move and dependent in the same cycle
		if ((slot_bottom.is_mtctr && slot_upper.ctr_dep) ||
			(slot_bottom.is_mtlr && slot_upper.lr_dep)) begin
			dec_u = 1'b0;
		end
		// bottom slot is an older uncompleted instruction
		if (slot_upper.pre_sync) begin
			dec_u = 1'b0;
		end
	end

	// post-sync interlock: decoded, then completed in n, drain in n+1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_q <= PS_IDLE;
		end else begin
			case (ps_q)
				PS_IDLE: begin
					if ((dec_b && slot_bottom.post_sync) ||
						(dec_u && slot_upper.post_sync)) begin
						ps_q <= PS_PEND;
					end
				end
				PS_PEND: begin
					if (psync_done) begin
						ps_q <= PS_DRAIN;
					end
				end
				PS_DRAIN: begin
					ps_q <= PS_IDLE;
				end
				default: begin
					ps_q <= PS_IDLE;
				end
			endcase
		end
	end

	// interlock flags, a new set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			br_lock_q  <= 1'b0;
			ctr_pend_q <= 1'b0;
			lr_pend_q  <= 1'b0;
		end else begin
			if ((dec_b && slot_bottom.uncond_tgt_miss) ||
				(dec_u && slot_upper.uncond_tgt_miss)) begin
				br_lock_q <= 1'b1;
			end else if (ib_flush) begin
				br_lock_q <= 1'b0;
			end
			if ((dec_b && slot_bottom.is_mtctr) ||
				(dec_u && slot_upper.is_mtctr)) begin
				ctr_pend_q <= 1'b1;
			end else if (ctr_exec) begin
				ctr_pend_q <= 1'b0;
			end
			if ((dec_b && slot_bottom.is_mtlr) ||
				(dec_u && slot_upper.is_mtlr)) begin
				lr_pend_q <= 1'b1;
			end else if (lr_exec) begin
				lr_pend_q <= 1'b0;
			end
		end
	end

	// decode outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_bottom_q <= 1'b0;
			dec_upper_q  <= 1'b0;
		end else begin
			dec_bottom_q <= dec_b;
			dec_upper_q  <= dec_u;
		end
	end

	// issue grants for the two general heads and the branch head
	always_comb begin
		g0 = ctrl_q[CTRL_ISSUE_EN] && genq_head0.valid &&
			((genq_head0.unit & rs_busy) == '0) &&
			!(genq_head0.reads_full64 && genq_head0.low32_pending);
		g1 = ctrl_q[CTRL_ISSUE_EN] && genq_head1.valid &&
			((genq_head1.unit & rs_busy) == '0) &&
			!(genq_head1.reads_full64 && genq_head1.low32_pending);
		// same unit in order, one per station
		if ((genq_head0.unit & genq_head1.unit) != '0) begin
			g1 = 1'b0;
		end
		gb = ctrl_q[CTRL_ISSUE_EN] && brq_valid && !rs_busy[U_BR];
		// branch station already fed this cycle
		if ((g0 && genq_head0.unit[U_BR]) ||
			(g1 && genq_head1.unit[U_BR])) begin
			gb = 1'b0;
		end
	end

	// issue and execution start outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			issue_g0_q <= 1'b0;
			issue_g1_q <= 1'b0;
			issue_b_q  <= 1'b0;
			su_go_q    <= 2'h0;
		end else begin
			issue_g0_q <= g0;
			issue_g1_q <= g1;
			issue_b_q  <= gb;
			su_go_q    <= su_start;
		end
	end

	// apb decode, zero-wait slave answering in the first access cycle
	assign wr_en = psel && penable && pready && pwrite;

	always_comb begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		case (paddr)
			OFF_CTRL: rd_val[2:0] = ctrl_q;
			OFF_STAT: begin
				rd_val[STAT_PSYNC +: 2]  = ps_q;
				rd_val[STAT_BR_LOCK]     = br_lock_q;
				rd_val[STAT_CTR_PEND]    = ctr_pend_q;
				rd_val[STAT_LR_PEND]     = lr_pend_q;
				rd_val[STAT_MISS]        = miss_pend_q;
				rd_val[STAT_SU_BUSY +: 2] = su_busy;
			end
			OFF_DCNT: rd_val[15:0] = dcnt_q;
			default:  rd_hit = 1'b0;
		endcase
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_hit;
			prdata  <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
		end
	end

	// control register and decode counter, a write clears the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
			dcnt_q <= 16'h0;
		end else begin
			if (wr_en && paddr == OFF_CTRL) begin
				ctrl_q <= pwdata[2:0];
			end
			if (wr_en && paddr == OFF_DCNT) begin
				dcnt_q <= 16'h0;
			end else begin
				dcnt_q <= dcnt_q + {15'h0, dec_b} + {15'h0, dec_u};
			end
		end
	end

	// priority request blocks the next fetch output
	fetch_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
		fetch_in.prio_pending |=> !fetch_go_q)
		else $error("fetch started over a priority request");

	// a miss keeps fetch stalled until serviced
	fetch_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
		fetch_in.icache_miss ##1 !fetch_in.miss_done |=> !fetch_go_q [*2])
		else $error("fetch started during a miss");

	// no fetch without room
	fetch_room_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(fetch_in.instq_room && fetch_in.fq_room) |=> !fetch_go_q)
		else $error("fetch started without queue room");

	// drop follows a second-stage hit
	fetch_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		fetch_in.stage2_tgt_hit && fetch_in.stage1_valid |=> fetch_drop_q)
		else $error("first-stage fetch not dropped");

	// two-cycle decode gap after post-sync completion
	psync_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
		ps_q == PS_PEND && psync_done |=> !dec_bottom_q ##1 !dec_bottom_q)
		else $error("decode inside the post-sync gap");

	// flush and room interlocks
	cq_room_a: assert property (@(posedge pclk) disable iff (!presetn)
		(flush_active || cmpl_free < CMPL_FREE_NEED || genq_full)
		|=> !dec_bottom_q)
		else $error("decode despite flush or queue room");

	// one branch-class per cycle
	branch_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		slot_bottom.branch_class && slot_upper.branch_class |=> !dec_upper_q)
		else $error("two branch-class instructions decoded");

	// upper slot never alone
	upper_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		dec_upper_q |-> dec_bottom_q)
		else $error("upper slot decoded without bottom");

	// same-unit heads never issue together
	issue_unit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(genq_head0.unit & genq_head1.unit) != '0 |=> !issue_g1_q)
		else $error("second issue to the same unit");

endmodule : dfsc_front_ctl
`default_nettype wire

// >>> core/dfsc_pkg.sv
package dfsc_pkg;

	// execution unit indices in the one-hot unit vectors
	localparam int unsigned UNITS = 5;
	localparam int unsigned U_SC1 = 0;
	localparam int unsigned U_SC2 = 1;
	localparam int unsigned U_MU  = 2;
	localparam int unsigned U_LS  = 3;
	localparam int unsigned U_BR  = 4;

	// apb register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DCNT = 8'h08;

	// control register fields and reset value
	localparam int unsigned CTRL_FETCH_EN  = 0;
	localparam int unsigned CTRL_DECODE_EN = 1;
	localparam int unsigned CTRL_ISSUE_EN  = 2;
	localparam logic [2:0]  CTRL_RESET     = 3'h7;

	// status register fields
	localparam int unsigned STAT_PSYNC    = 0;
	localparam int unsigned STAT_BR_LOCK  = 2;
	localparam int unsigned STAT_CTR_PEND = 3;
	localparam int unsigned STAT_LR_PEND  = 4;
	localparam int unsigned STAT_MISS     = 5;
	localparam int unsigned STAT_SU_BUSY  = 6;

	// completion queue room needed before any decode, latency width
	localparam logic [3:0]  CMPL_FREE_NEED = 4'h2;
	localparam int unsigned LAT_W          = 3;
	localparam logic [LAT_W-1:0] LAT_ONE   = 3'h1;

	// post-sync interlock states, gray along idle -> pend -> drain
	typedef enum logic [1:0] {
		PS_IDLE  = 2'b00,
		PS_PEND  = 2'b01,
		PS_DRAIN = 2'b11
	} dfsc_psync_type;

	// one instruction queue slot as seen by decode
	typedef struct packed {
		logic valid;
		logic post_sync;
		logic pre_sync;
		logic ctr_dep;
		logic lr_dep;
		logic brk_before;
		logic brk_after;
		logic branch_class;
		logic is_mtctr;
		logic is_mtlr;
		logic uncond_tgt_miss;
	} dfsc_slot_type;

	// fetch request conditions
	typedef struct packed {
		logic prio_pending;
		logic itlb_miss;
		logic icache_miss;
		logic miss_done;
		logic instq_room;
		logic fq_room;
		logic stage2_tgt_hit;
		logic stage1_valid;
	} dfsc_fetch_type;

	// issue queue head candidate
	typedef struct packed {
		logic             valid;
		logic [UNITS-1:0] unit;
		logic             reads_full64;
		logic             low32_pending;
	} dfsc_cand_type;

	// single-cycle unit start conditions
	typedef struct packed {
		logic             has_new;
		logic             ops_ready;
		logic [LAT_W-1:0] latency;
	} dfsc_su_type;

endpackage : dfsc_pkg

// >>> core/dfsc_slot_check.sv
`timescale 1ns/100ps
`default_nettype none

// per-slot decode checks that do not depend on slot position
module dfsc_slot_check
	import dfsc_pkg::*;
(
	// slot and pipeline state
	input  wire dfsc_slot_type slot,
	input  wire logic          ctr_pend,
	input  wire logic          lr_pend,
	input  wire logic          cmpl_empty,
	input  wire logic          brq_full,
	// verdict
	output logic               ok
);

	logic branchy;

	// move-to-count and move-to-link also wait on branch queue room
	assign branchy = slot.branch_class | slot.is_mtctr | slot.is_mtlr;

	// combine slot checks
	always_comb begin
		ok = slot.valid;
		if (slot.pre_sync && !cmpl_empty) begin
			ok = 1'b0;
		end
		if ((slot.ctr_dep && ctr_pend) || (slot.lr_dep && lr_pend)) begin
			ok = 1'b0;
		end
		if (branchy && brq_full) begin
			ok = 1'b0;
		end
	end

endmodule : dfsc_slot_check
`default_nettype wire

// >>> core/dfsc_su_start.sv
`timescale 1ns/100ps
`default_nettype none

// start control for one single-cycle unit with multi-cycle busy tracking
module dfsc_su_start
	import dfsc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// request
	input  wire dfsc_su_type su,
	// result
	output logic             start,
	output logic             busy
);

	logic [LAT_W-1:0] busy_q;

	assign busy = (busy_q != '0);

	assign start = su.has_new && su.ops_ready && !busy;

	// count remaining cycles of a multi-cycle operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= '0;
		end else if (start && su.latency > LAT_ONE) begin
			busy_q <= su.latency - LAT_ONE;
		end else if (busy) begin
			busy_q <= busy_q - LAT_ONE;
		end
	end

	// a three-cycle op blocks the next two cycles
	su_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		start && su.latency == 3'h3 |=> !start [*2])
		else $error("single-cycle unit started while busy");

	// no start without operands
	su_ops_a: assert property (@(posedge pclk) disable iff (!presetn)
		!su.ops_ready |-> !start)
		else $error("single-cycle unit started without operands");

endmodule : dfsc_su_start
`default_nettype wire

// >>> test/dfsc_front_ctl_test.sv
`timescale 1ns/100ps
`default_nettype none

module dfsc_front_ctl_test
	import dfsc_pkg::*;
;
	// bus, pipeline and bench signals
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	dfsc_fetch_type   fetch_in, f;
	dfsc_slot_type    slot_bottom, slot_upper, v, s, m, d;
	dfsc_cand_type    genq_head0, genq_head1, c1, c2, cb, cw;
	dfsc_su_type      su_one, su_two, ok1, nr, u;
	logic [3:0]       cmpl_free;
	logic [UNITS-1:0] rs_busy;
	logic             cmpl_empty, brq_full, genq_full, flush_active, ib_flush;
	logic             psync_done, ctr_exec, lr_exec, brq_valid, er;
	logic             fetch_go_q, fetch_drop_q, dec_bottom_q, dec_upper_q;
	logic             issue_g0_q, issue_g1_q, issue_b_q;
	logic [1:0]       su_go_q;
	int               failures, compares;
	localparam dfsc_fetch_type F0 =
		'{instq_room:1'b1, fq_room:1'b1, default:1'b0};

	dfsc_front_ctl u_dfsc_front_ctl (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .fetch_in, .fetch_go_q, .fetch_drop_q,
		.slot_bottom, .slot_upper, .cmpl_free, .cmpl_empty, .brq_full,
		.genq_full, .flush_active, .ib_flush, .psync_done, .ctr_exec,
		.lr_exec, .dec_bottom_q, .dec_upper_q, .genq_head0, .genq_head1,
		.brq_valid, .rs_busy, .issue_g0_q, .issue_g1_q, .issue_b_q, .su_one,
		.su_two, .su_go_q
	);

	// 200 mhz clock
	always #2.5 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		if (failures == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// ready, read data and error are all taken at one rising edge
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge pclk);
			n++;
		end
		if (n == 16) begin
			failures++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// quiet pipeline inputs, then look at the registered decision
	task automatic settle;
		@(posedge pclk);
		slot_bottom <= '0;
		slot_upper  <= '0;
		fetch_in    <= F0;
		genq_head0  <= '0;
		genq_head1  <= '0;
		brq_valid   <= 1'b0;
		rs_busy     <= '0;
		su_one      <= '0;
		su_two      <= '0;
		@(negedge pclk);
	endtask : settle

	task automatic nc;
		@(posedge pclk);
		@(negedge pclk);
	endtask : nc

	task automatic dec(input dfsc_slot_type b, input dfsc_slot_type t,
		input logic [1:0] e);
		@(posedge pclk);
		slot_bottom <= b;
		slot_upper  <= t;
		settle();
		chk(32'({dec_bottom_q, dec_upper_q}), 32'(e));
	endtask : dec

	task automatic fet(input dfsc_fetch_type x, input logic e);
		@(posedge pclk);
		fetch_in <= x;
		settle();
		chk(32'(fetch_go_q), 32'(e));
		chk(32'(fetch_drop_q), 32'h0);
	endtask : fet

	task automatic iss(input dfsc_cand_type h0, input dfsc_cand_type h1,
		input logic bv, input logic [4:0] busy, input logic [2:0] e);
		@(posedge pclk);
		genq_head0 <= h0;
		genq_head1 <= h1;
		brq_valid  <= bv;
		rs_busy   <= busy;
		settle();
		chk(32'({issue_g0_q, issue_g1_q, issue_b_q}), 32'(e));
	endtask : iss

	task automatic su(input dfsc_su_type a, input dfsc_su_type b,
		input logic [1:0] e);
		@(posedge pclk);
		su_one <= a;
		su_two <= b;
		settle();
		chk(32'(su_go_q), 32'(e));
	endtask : su

	// main sequence
	initial begin
		failures = 0;
		compares = 0;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cmpl_empty, brq_full, genq_full, flush_active, ib_flush} = '0;
		{psync_done, ctr_exec, lr_exec} = '0;
		cmpl_free = 4'h2;
		settle();
		v = '{valid:1'b1, default:1'b0};
		c1 = '{valid:1'b1, unit:5'h01, default:'0};
		c2 = '{valid:1'b1, unit:5'h02, default:'0};
		cb = '{valid:1'b1, unit:5'h10, default:'0};
		cw = '{valid:1'b1, unit:5'h01, reads_full64:1'b1, low32_pending:1'b1};
		ok1 = '{has_new:1'b1, ops_ready:1'b1, latency:LAT_ONE};
		nr = '{has_new:1'b1, ops_ready:1'b0, latency:LAT_ONE};
		// release after the second reset edge, on a rising edge
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h7);
		chk(32'(er), 32'h0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, OFF_CTRL, 32'h0);
		fet(F0, 1'b0);
		dec(v, v, 2'b00);
		apb(1'b1, OFF_CTRL, 32'hffffffff);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h7);
		apb(1'b1, OFF_DCNT, 32'h0);
		dec(v, v, 2'b11);
		apb(1'b0, OFF_DCNT, 32'h0);
		chk(rd, 32'h2);
		dec('0, '0, 2'b00);
		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			cmpl_free    <= (k == 0) ? 4'h1 : 4'h2;
			genq_full    <= (k == 1);
			flush_active <= (k == 2);
			dec(v, '0, 2'b00);
		end
		@(posedge pclk);
		flush_active <= 1'b0;
		s = '{valid:1'b1, brk_before:1'b1, default:1'b0};
		dec(v, s, 2'b10);
		s = '{valid:1'b1, brk_after:1'b1, default:1'b0};
		dec(s, v, 2'b10);
		s = '{valid:1'b1, branch_class:1'b1, default:1'b0};
		dec(s, s, 2'b10);
		@(posedge pclk);
		brq_full <= 1'b1;
		dec(s, '0, 2'b00);
		m = '{valid:1'b1, is_mtlr:1'b1, default:1'b0};
		dec(m, '0, 2'b00);
		dec(v, '0, 2'b10);
		@(posedge pclk);
		brq_full <= 1'b0;
		s = '{valid:1'b1, pre_sync:1'b1, default:1'b0};
		dec(s, '0, 2'b00);
		dec(s, v, 2'b00);
		@(posedge pclk);
		cmpl_empty <= 1'b1;
		dec(s, '0, 2'b10);
		@(posedge pclk);
		cmpl_empty <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			m = v;
			m.is_mtctr = (i == 0);
			m.is_mtlr = (i == 1);
			d = v;
			d.ctr_dep = (i == 0);
			d.lr_dep = (i == 1);
			dec(m, '0, 2'b10);
			dec(d, '0, 2'b00);
			@(posedge pclk);
			ctr_exec <= (i == 0);
			lr_exec  <= (i == 1);
			@(posedge pclk);
			ctr_exec <= 1'b0;
			lr_exec  <= 1'b0;
			dec(d, '0, 2'b10);
		end
		s = '{valid:1'b1, uncond_tgt_miss:1'b1, default:1'b0};
		dec(s, '0, 2'b10);
		dec(v, '0, 2'b00);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h1 << STAT_BR_LOCK);
		@(posedge pclk);
		ib_flush <= 1'b1;
		@(posedge pclk);
		ib_flush <= 1'b0;
		dec(v, '0, 2'b10);
		s = '{valid:1'b1, post_sync:1'b1, default:1'b0};
		dec(s, '0, 2'b10);
		dec(v, '0, 2'b00);
		@(posedge pclk);
		slot_bottom   <= v;
		psync_done    <= 1'b1;
		@(posedge pclk);
		psync_done <= 1'b0;
		@(negedge pclk);
		chk(32'(dec_bottom_q), 32'h0);
		nc();
		chk(32'(dec_bottom_q), 32'h0);
		nc();
		chk(32'(dec_bottom_q), 32'h1);
		fet(F0, 1'b1);
		for (int k = 0; k < 3; k++) begin
			f = F0;
			f.prio_pending = (k == 0);
			f.instq_room = (k != 1);
			f.fq_room = (k != 2);
			fet(f, 1'b0);
		end
		for (int i = 0; i < 2; i++) begin
			f = F0;
			f.itlb_miss = (i == 0);
			f.icache_miss = (i == 1);
			@(posedge pclk);
			fetch_in <= f;
			@(posedge pclk);
			fetch_in <= F0;
			fet(F0, 1'b0);
			f = F0;
			f.miss_done = 1'b1;
			@(posedge pclk);
			fetch_in <= f;
			@(posedge pclk);
			fetch_in <= F0;
			fet(F0, 1'b1);
		end
		f = F0;
		f.stage2_tgt_hit = 1'b1;
		f.stage1_valid = 1'b1;
		@(posedge pclk);
		fetch_in <= f;
		settle();
		chk(32'(fetch_drop_q), 32'h1);
		iss(c1, c2, 1'b1, 5'h00, 3'b111);
		iss(c1, c2, 1'b0, 5'h01, 3'b010);
		iss(c1, c1, 1'b0, 5'h00, 3'b100);
		iss(cw, '0, 1'b0, 5'h00, 3'b000);
		iss(cb, '0, 1'b1, 5'h00, 3'b100);
		iss('0, '0, 1'b1, 5'h10, 3'b000);
		su(ok1, ok1, 2'b11);
		su(nr, ok1, 2'b10);
		u = ok1;
		u.latency = 3'h3;
		@(posedge pclk);
		su_one <= u;
		@(posedge pclk);
		su_one <= ok1;
		@(negedge pclk);
		chk(32'(su_go_q), 32'h1);
		nc();
		chk(32'(su_go_q), 32'h0);
		nc();
		chk(32'(su_go_q), 32'h0);
		nc();
		chk(32'(su_go_q), 32'h1);
		test_done();
	end

endmodule : dfsc_front_ctl_test

`default_nettype wire
